//--- mcs_params.svh
// Constants for the modem command and status register bank.
// Assumes inclusion by bare name; definitions only.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// Register indices as seen by the rack and the two protocol ports
`define MCS_IDX_COMMAND 4'h1
`define MCS_IDX_STATUS 4'h2
`define MCS_IDX_PORT_BAUD 4'h3
`define MCS_IDX_LINE_BAUD 4'h4
`define MCS_IDX_DIAL_PTR 4'h5
`define MCS_IDX_ERROR 4'h6
`define MCS_IDX_PASSWORD 4'h7
`define MCS_IDX_LAST_PWD 4'h8
`define MCS_IDX_RESERVED 4'h9

// Bit positions in command and status words (bit 1 is position 0)
`define MCS_B_CONNECT 0
`define MCS_B_RTS_CTS 1
`define MCS_B_MULTIDROP 2
`define MCS_B_TRANSPARENT 3
`define MCS_B_AUTO_ANSWER 4
`define MCS_B_RADIO_KEY 5
`define MCS_B_WATCHDOG 6
`define MCS_B_PPAR_NONE 7
`define MCS_B_PPAR_ODD 8
`define MCS_B_LPAR_NONE 9
`define MCS_B_LPAR_ODD 10
`define MCS_B_PORT_CRC 11
`define MCS_B_LINE_CRC 12
`define MCS_B_LEASED 13
`define MCS_B_TWO_WIRE_HOOK 14
`define MCS_B_RING 15

// Error word flag positions (bit 7 and bit 2, counted from 1)
`define MCS_E_PORT_PAR 6
`define MCS_E_LINE_PAR 1

// Reset values
`define MCS_RST_WORD 16'h0000
`define MCS_PAR_EVEN 2'h0

// Valid range of the phone-number pointer
`define MCS_DIAL_PTR_MIN 16'h000A
`define MCS_DIAL_PTR_MAX 16'h0800

`endif

//--- mcs_pkg.sv
// Types shared by the modem command and status register bank.
// Assumes mcs_params.svh is on the include path.
package mcs_pkg;

    // One register write from one source
    typedef struct packed {
        logic en;           // Write strobe, one cycle
        logic [3:0] idx;    // Register index
        logic [15:0] data;  // Write data
    } mcs_wr_t;

    // Effective operating settings driven to the modem core
    typedef struct packed {
        logic multidrop;    // Multidrop operation
        logic transparent;  // AT-command transparent mode
        logic originate;    // Auto-answer disabled
        logic watchdog_en;  // Dial-input watchdog on
        logic [1:0] port_par; // Port parity {odd, none}
        logic [1:0] line_par; // Line parity {odd, none}
        logic port_crc;     // Port frame check is CRC
        logic line_crc;     // Line frame check is CRC
        logic leased;       // Leased-line operation
        logic two_wire;     // Two-wire leased line
    } mcs_cfg_t;

    // Hook control states, one-hot
    typedef enum logic [2:0] {
        HK_ON = 3'h1,
        HK_OFF = 3'h2,
        HK_DIAL = 3'h4
    } mcs_hook_t;

endpackage : mcs_pkg

//--- mcs_plc_model.sv
// PLC on the rack backplane: writes and reads bank registers.
// Assumes a write is taken on the rising edge with en high.
`timescale 1ns/1ps
module mcs_plc_model
    import mcs_pkg::*;
(
    input wire logic clk_i, // Bank clock
    input wire logic [15:0] rdata_i, // Read data
    output mcs_wr_t wr_o, // Write request
    output logic [3:0] raddr_o // Read index
);
    initial begin
        wr_o = '0;
        raddr_o = 4'h0;
    end
    // Write held over one rising edge, then released
    task automatic put_word(input logic [3:0] idx, input logic [15:0] data);
        @(negedge clk_i);
        wr_o = '{en: 1'b1, idx: idx, data: data};
        @(negedge clk_i);
        wr_o.en = 1'b0;
        wr_o.data = ~data; // Released bus shows no stale word
    endtask : put_word
    // Index sampled on a rising edge, data one cycle later
    task automatic get_word(input logic [3:0] idx, output logic [15:0] data);
        @(negedge clk_i);
        raddr_o = idx;
        @(negedge clk_i);
        data = rdata_i;
    endtask : get_word
endmodule : mcs_plc_model

//--- mcs_regs.sv
// Command/status register bank of the line modem module.
// Assumes one 25 MHz clock, synchronous reset, and that modem pins
// (carrier, CTS, dial input, ring) arrive asynchronously.
//
// Operation
// - PLC writes command word through rack addressing
// - Status word is read-only to PLC
// - Act only on command bit changes
// - Status word always shows live settings
// - Connect bit falling hangs up in dial-up
// - Connect rising goes off hook, dials valid
// - Status bit 1 shows carrier detect
// - Command bit 2 set asserts RTS
// - Command bit 2 cleared drops RTS
// - Status bit 2 mirrors CTS input
// - Bit 3 point-to-point or multidrop
// - Bit 4 native or transparent mode
// - Bit 5 auto-answer or originate
// - Bit 6 drives radio key relay
// - Bit 7 watchdog; status shows dial input
// - Bits 8-9 encode port parity
// - Bits 10-11 encode line parity
// - Bit 12 port frame check select
// - Bit 13 line frame check select
// - Bit 14 dial-up or leased line
// - Bit 15 wire count or hook state
// - Invalid parity means even, sets error flag
// - Multidrop needs transparent and leased mode
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_regs
    import mcs_pkg::*;
(
    input wire logic CLK_I,            // 25 MHz clock
    input wire logic SRST_I,           // Synchronous reset, high
    input wire mcs_wr_t RACK_WR_I,     // PLC write over rack
    input wire mcs_wr_t PORT_WR_I,     // Serial data port write
    input wire mcs_wr_t LINE_WR_I,     // Modem line port write
    input wire logic [3:0] RACK_RADDR_I, // PLC read index
    output logic [15:0] RACK_RDATA_O,  // PLC read data, one cycle late
    input wire logic CARRIER_I,        // Carrier detect pin
    input wire logic CTS_I,            // Serial port CTS pin
    input wire logic DIAL_IN_I,        // Front-panel dial input pin
    input wire logic RING_I,           // Line ringing pin
    output logic RTS_O,                // Serial port RTS
    output logic RADIO_KEY_O,          // Radio key relay drive
    output logic OFF_HOOK_O,           // Line off hook
    output logic DIAL_START_O,         // Pulse: dial stored number
    output logic HANG_UP_O,            // Pulse: disconnect now
    output mcs_cfg_t CFG_O             // Effective settings
);

    // Parity field fix-up: both bits set falls back to even
    function automatic logic [1:0] mcs_par_fix(input logic [1:0] f);
        logic [1:0] r;
        r = (&f) ? `MCS_PAR_EVEN : f;
        return r;
    endfunction : mcs_par_fix

    // Pointer check for a valid stored number block
    function automatic logic mcs_ptr_ok(input logic [15:0] p);
        logic ok;
        ok = (p >= `MCS_DIAL_PTR_MIN) && (p <= `MCS_DIAL_PTR_MAX);
        return ok;
    endfunction : mcs_ptr_ok

    // Input synchronisers: stage 1 feeds only stage 2
    logic [3:0] pin_s1_reg;            // First stage
    logic [3:0] pin_s2_reg;            // Second stage, safe to read
    logic dial_prev_reg;               // Dial input, one cycle older
    logic ring_prev_reg;               // Ring input, one cycle older
    logic carrier_q;                   // Synchronised carrier
    logic cts_q;                       // Synchronised CTS
    logic dial_q;                      // Synchronised dial input
    logic ring_q;                      // Synchronised ring

    // Register storage
    logic [15:0] cmd_reg;              // Last command word written
    logic [15:0] port_baud_reg;        // Port baud rate code
    logic [15:0] line_baud_reg;        // Line baud rate code
    logic [15:0] dial_ptr_reg;         // Phone-number pointer
    logic [15:0] err_reg;              // Error word
    logic [15:0] err_next;             // Next error word
    logic [15:0] pwd_reg;              // Access password
    logic [15:0] last_pwd_reg;         // Last password received
    logic [15:0] rdata_reg;            // Registered read data
    logic [15:0] status_w;             // Live status word

    // Effective settings and actuators
    mcs_cfg_t cfg_reg;                 // Current settings
    mcs_cfg_t cfg_next;                // Settings after this write
    logic rts_reg;                     // RTS drive
    logic rts_next;                    // Next RTS drive
    logic key_reg;                     // Radio key relay
    logic key_next;                    // Next relay state
    logic hang_reg;                    // Hang-up pulse

    // Hook control
    mcs_hook_t hk_reg;                 // Hook state
    mcs_hook_t hk_next;                // Next hook state
    logic hang_next;                   // Hang-up pulse next

    // Write arbitration and change detection
    mcs_wr_t wsel;                     // Winning write this cycle
    logic wsel_rack;                   // Winner is the PLC
    logic cmd_wr;                      // Command word written
    logic [15:0] chg;                  // Bits that change value
    logic conn_rise;                   // Connect bit goes to one
    logic conn_fall;                   // Connect bit goes to zero
    logic dial_rise;                   // Dial input turned on
    logic dial_fall;                   // Dial input turned off
    logic ring_rise;                   // Ringing began

    assign carrier_q = pin_s2_reg[0];
    assign cts_q = pin_s2_reg[1];
    assign dial_q = pin_s2_reg[2];
    assign ring_q = pin_s2_reg[3];

    // Two-flop synchronisers and edge history
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            dial_prev_reg <= 1'b0;
            ring_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {RING_I, DIAL_IN_I, CTS_I, CARRIER_I};
            pin_s2_reg <= pin_s1_reg;
            dial_prev_reg <= dial_q;
            ring_prev_reg <= ring_q;
        end
    end

    assign dial_rise = dial_q & ~dial_prev_reg;
    assign dial_fall = ~dial_q & dial_prev_reg;
    assign ring_rise = ring_q & ~ring_prev_reg;

    // One writer per cycle: rack first, then data port, then line port
    always_comb begin
        wsel = '0;
        wsel_rack = 1'b0;
        if (RACK_WR_I.en) begin
            wsel = RACK_WR_I;
            wsel_rack = 1'b1;
        end else if (PORT_WR_I.en) begin
            wsel = PORT_WR_I;
        end else if (LINE_WR_I.en) begin
            wsel = LINE_WR_I;
        end
    end

    // Command write and per-bit change mask against the shared copy
    assign cmd_wr = wsel.en && (wsel.idx == `MCS_IDX_COMMAND);
    assign chg = cmd_wr ? (wsel.data ^ cmd_reg) : 16'h0000;
    assign conn_rise = chg[`MCS_B_CONNECT] & wsel.data[`MCS_B_CONNECT];
    assign conn_fall = chg[`MCS_B_CONNECT] & ~wsel.data[`MCS_B_CONNECT];

    // Command word copy, shared by all three writers
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cmd_reg <= `MCS_RST_WORD;
        end else if (cmd_wr) begin
            cmd_reg <= wsel.data;
        end
    end

    // Plain configuration registers; any source may write them
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            port_baud_reg <= `MCS_RST_WORD;
            line_baud_reg <= `MCS_RST_WORD;
            dial_ptr_reg <= `MCS_RST_WORD;
            pwd_reg <= `MCS_RST_WORD;
        end else if (wsel.en) begin
            case (wsel.idx)
                `MCS_IDX_PORT_BAUD: begin
                    port_baud_reg <= wsel.data;
                end
                `MCS_IDX_LINE_BAUD: begin
                    line_baud_reg <= wsel.data;
                end
                `MCS_IDX_DIAL_PTR: begin
                    dial_ptr_reg <= wsel.data;
                end
                `MCS_IDX_PASSWORD: begin
                    pwd_reg <= wsel.data;
                end
                default: begin
                    // Read-only, reserved and unmapped: no change
                end
            endcase
        end
    end

    // Last password: read-only to the PLC, loaded by the protocol ports
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            last_pwd_reg <= `MCS_RST_WORD;
        end else if (wsel.en && !wsel_rack && (wsel.idx == `MCS_IDX_LAST_PWD)) begin
            last_pwd_reg <= wsel.data;
        end
    end

    // Settings follow only the command bits that changed
    always_comb begin
        cfg_next = cfg_reg;
        rts_next = rts_reg;
        key_next = key_reg;
        err_next = err_reg;
        if (chg[`MCS_B_RTS_CTS]) begin
            rts_next = wsel.data[`MCS_B_RTS_CTS];
        end
        if (chg[`MCS_B_TRANSPARENT]) begin
            cfg_next.transparent = wsel.data[`MCS_B_TRANSPARENT];
        end
        if (chg[`MCS_B_AUTO_ANSWER]) begin
            cfg_next.originate = wsel.data[`MCS_B_AUTO_ANSWER];
        end
        if (chg[`MCS_B_RADIO_KEY]) begin
            key_next = wsel.data[`MCS_B_RADIO_KEY];
        end
        if (chg[`MCS_B_WATCHDOG]) begin
            cfg_next.watchdog_en = wsel.data[`MCS_B_WATCHDOG];
        end
        if (chg[`MCS_B_PPAR_NONE] | chg[`MCS_B_PPAR_ODD]) begin
            // Port parity field, bad code falls back to even
            cfg_next.port_par = mcs_par_fix(wsel.data[`MCS_B_PPAR_ODD:`MCS_B_PPAR_NONE]);
            err_next[`MCS_E_PORT_PAR] = &wsel.data[`MCS_B_PPAR_ODD:`MCS_B_PPAR_NONE];
        end
        if (chg[`MCS_B_LPAR_NONE] | chg[`MCS_B_LPAR_ODD]) begin
            // Line parity field, same handling
            cfg_next.line_par = mcs_par_fix(wsel.data[`MCS_B_LPAR_ODD:`MCS_B_LPAR_NONE]);
            err_next[`MCS_E_LINE_PAR] = &wsel.data[`MCS_B_LPAR_ODD:`MCS_B_LPAR_NONE];
        end
        if (chg[`MCS_B_PORT_CRC]) begin
            cfg_next.port_crc = wsel.data[`MCS_B_PORT_CRC];
        end
        if (chg[`MCS_B_LINE_CRC]) begin
            cfg_next.line_crc = wsel.data[`MCS_B_LINE_CRC];
        end
        if (chg[`MCS_B_LEASED]) begin
            cfg_next.leased = wsel.data[`MCS_B_LEASED];
        end
        if (chg[`MCS_B_TWO_WIRE_HOOK]) begin
            cfg_next.two_wire = wsel.data[`MCS_B_TWO_WIRE_HOOK];
        end
        if (chg[`MCS_B_MULTIDROP] | chg[`MCS_B_TRANSPARENT] | chg[`MCS_B_LEASED]) begin
            cfg_next.multidrop = wsel.data[`MCS_B_MULTIDROP];
        end
        // Multidrop dropped when not transparent or not leased
        if (!cfg_next.transparent || !cfg_next.leased) begin
            cfg_next.multidrop = 1'b0;
        end
    end

    // Settings, actuators and error word
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cfg_reg <= '0;
            rts_reg <= 1'b0;
            key_reg <= 1'b0;
            err_reg <= `MCS_RST_WORD;
        end else begin
            cfg_reg <= cfg_next;
            rts_reg <= rts_next;
            key_reg <= key_next;
            err_reg <= err_next;
        end
    end

    // Hook control: connect bit, dial input and ringing
    always_comb begin
        hk_next = hk_reg;
        hang_next = 1'b0;
        case (hk_reg)
            HK_ON: begin
                // Off hook on connect edge, dial input, or answered ring
                if (!cfg_reg.leased && (conn_rise || dial_rise ||
                    (ring_rise && !cfg_reg.originate))) begin
                    if (mcs_ptr_ok(dial_ptr_reg) && (conn_rise || dial_rise)) begin
                        hk_next = HK_DIAL;
                    end else begin
                        hk_next = HK_OFF;
                    end
                end
            end
            HK_DIAL: begin
                // One-cycle dial request, then hold off hook
                hk_next = HK_OFF;
            end
            HK_OFF: begin
                if (cfg_reg.leased) begin
                    // Leased line has no hook: release quietly
                    hk_next = HK_ON;
                end else if (conn_fall || dial_fall) begin
                    hk_next = HK_ON;
                    hang_next = 1'b1;
                end
            end
            default: begin
                hk_next = HK_ON;
            end
        endcase
    end

    // Hook state and hang-up pulse
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            hk_reg <= HK_ON;
            hang_reg <= 1'b0;
        end else begin
            hk_reg <= hk_next;
            hang_reg <= hang_next;
        end
    end

    // Live status word, built from present state every cycle
    always_comb begin
        status_w = 16'h0000;
        status_w[`MCS_B_CONNECT] = carrier_q;
        status_w[`MCS_B_RTS_CTS] = cts_q;
        status_w[`MCS_B_MULTIDROP] = cfg_reg.multidrop;
        status_w[`MCS_B_TRANSPARENT] = cfg_reg.transparent;
        status_w[`MCS_B_AUTO_ANSWER] = cfg_reg.originate;
        status_w[`MCS_B_RADIO_KEY] = key_reg;
        status_w[`MCS_B_WATCHDOG] = dial_q;
        status_w[`MCS_B_PPAR_ODD:`MCS_B_PPAR_NONE] = cfg_reg.port_par;
        status_w[`MCS_B_LPAR_ODD:`MCS_B_LPAR_NONE] = cfg_reg.line_par;
        status_w[`MCS_B_PORT_CRC] = cfg_reg.port_crc;
        status_w[`MCS_B_LINE_CRC] = cfg_reg.line_crc;
        status_w[`MCS_B_LEASED] = cfg_reg.leased;
        // Wire count in leased mode, hook state in dial-up
        status_w[`MCS_B_TWO_WIRE_HOOK] = cfg_reg.leased ? cfg_reg.two_wire : (hk_reg != HK_ON);
        // Ringing shown only until the line goes off hook
        status_w[`MCS_B_RING] = ring_q & (hk_reg == HK_ON) & ~cfg_reg.leased;
    end

    // Rack read port, one cycle of latency; status never writable
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rdata_reg <= 16'h0000;
        end else begin
            case (RACK_RADDR_I)
                `MCS_IDX_COMMAND: begin
                    rdata_reg <= cmd_reg;
                end
                `MCS_IDX_STATUS: begin
                    rdata_reg <= status_w;
                end
                `MCS_IDX_PORT_BAUD: begin
                    rdata_reg <= port_baud_reg;
                end
                `MCS_IDX_LINE_BAUD: begin
                    rdata_reg <= line_baud_reg;
                end
                `MCS_IDX_DIAL_PTR: begin
                    rdata_reg <= dial_ptr_reg;
                end
                `MCS_IDX_ERROR: begin
                    rdata_reg <= err_reg;
                end
                `MCS_IDX_PASSWORD: begin
                    rdata_reg <= pwd_reg;
                end
                `MCS_IDX_LAST_PWD: begin
                    rdata_reg <= last_pwd_reg;
                end
                default: begin
                    // Reserved and unmapped read as zero
                    rdata_reg <= 16'h0000;
                end
            endcase
        end
    end

    // Outputs
    assign RACK_RDATA_O = rdata_reg;
    assign RTS_O = rts_reg;
    assign RADIO_KEY_O = key_reg;
    assign OFF_HOOK_O = ~hk_reg[0];
    assign DIAL_START_O = hk_reg[2];
    assign HANG_UP_O = hang_reg;
    assign CFG_O = cfg_reg;

endmodule : mcs_regs

//--- mcs_regs_checker.sv
// Port-level assertions for the command/status register bank.
// Assumes binding to mcs_regs; sees only its ports.
`timescale 1ns/1ps
module mcs_regs_checker
    import mcs_pkg::*;
(
    input wire logic CLK_I, // Clock
    input wire logic SRST_I, // Reset
    input wire mcs_wr_t RACK_WR_I, // Rack write
    input wire logic [3:0] RACK_RADDR_I, // Read index
    input wire logic [15:0] RACK_RDATA_O, // Read data
    input wire logic RTS_O, // RTS drive
    input wire logic RADIO_KEY_O, // Relay drive
    input wire logic OFF_HOOK_O, // Hook state
    input wire logic DIAL_START_O, // Dial pulse
    input wire logic HANG_UP_O, // Hang-up pulse
    input wire mcs_cfg_t CFG_O // Settings
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    logic cmd_wr; // Rack command write taken
    logic [15:0] wd; // Rack write data
    logic [10:0] stat_exp; // Status bits predicted from settings
    assign cmd_wr = RACK_WR_I.en && RACK_WR_I.idx == 4'h1;
    assign wd = RACK_WR_I.data;
    assign stat_exp = {CFG_O.leased, CFG_O.line_crc, CFG_O.port_crc, CFG_O.line_par, CFG_O.port_par,
        RADIO_KEY_O, CFG_O.originate, CFG_O.transparent, CFG_O.multidrop};
    a_rts_follows_cmd: assert property (cmd_wr |=> RTS_O == $past(wd[1]))
        else $error("RTS does not follow command bit");
    a_key_crc_lease: assert property (cmd_wr |=>
        {RADIO_KEY_O, CFG_O.port_crc, CFG_O.line_crc, CFG_O.leased} ==
        {$past(wd[5]), $past(wd[11]), $past(wd[12]), $past(wd[13])}) else $error("Relay or line settings wrong");
    a_mode_bits: assert property (cmd_wr |=>
        {CFG_O.originate, CFG_O.transparent} == $past(wd[4:3])) else $error("Mode bits wrong");
    a_multidrop_gate: assert property (cmd_wr |=>
        CFG_O.multidrop == ($past(wd[2]) && $past(wd[3]) && $past(wd[13]))) else $error("Multidrop gating wrong");
    a_port_parity: assert property (cmd_wr |=>
        CFG_O.port_par == ($past(wd[8:7]) == 2'h3 ? 2'h0 : $past(wd[8:7]))) else $error("Port parity wrong");
    a_line_parity: assert property (cmd_wr |=>
        CFG_O.line_par == ($past(wd[10:9]) == 2'h3 ? 2'h0 : $past(wd[10:9]))) else $error("Line parity wrong");
    a_reserved_zero: assert property ($past(RACK_RADDR_I) inside {4'h0, [4'h9:4'hF]} |->
        RACK_RDATA_O == 16'h0000) else $error("Unmapped read not zero");
    a_status_mirror: assert property ($past(RACK_RADDR_I) == 4'h2 |->
        {RACK_RDATA_O[13:7], RACK_RDATA_O[5:2]} == $past(stat_exp)) else $error("Status word stale");
    a_hook_status: assert property ($past(RACK_RADDR_I) == 4'h2 && !$past(CFG_O.leased) |->
        RACK_RDATA_O[14] == $past(OFF_HOOK_O)) else $error("Hook status wrong");
    a_hang_pulse: assert property (HANG_UP_O |-> (!OFF_HOOK_O && $past(OFF_HOOK_O)) ##1 !HANG_UP_O)
        else $error("Hang-up pulse wrong");
    a_dial_pulse: assert property (DIAL_START_O |-> OFF_HOOK_O ##1 !DIAL_START_O)
        else $error("Dial pulse wrong");
    c_dial: cover property (DIAL_START_O);
    c_hang: cover property (HANG_UP_O);
    c_mdrop: cover property (CFG_O.multidrop);
endmodule : mcs_regs_checker

bind mcs_regs mcs_regs_checker mcs_regs_checker_inst (.CLK_I(CLK_I), .SRST_I(SRST_I), .RACK_WR_I(RACK_WR_I),
    .RACK_RADDR_I(RACK_RADDR_I), .RACK_RDATA_O(RACK_RDATA_O), .RTS_O(RTS_O), .RADIO_KEY_O(RADIO_KEY_O),
    .OFF_HOOK_O(OFF_HOOK_O), .DIAL_START_O(DIAL_START_O), .HANG_UP_O(HANG_UP_O), .CFG_O(CFG_O));

//--- mcs_regs_tb.sv
// Self-checking bench for the command/status register bank.
// Assumes the PLC model on the rack side; pins driven here.
`timescale 1ns/1ps
module mcs_regs_tb
    import mcs_pkg::*;
;
    logic clk = 1'b0; // 25 MHz clock
    logic srst = 1'b1; // Reset
    mcs_wr_t port_wr = '0; // Serial port write
    mcs_wr_t line_wr = '0; // Line port write
    mcs_wr_t rack_wr; // PLC write
    logic [3:0] raddr; // PLC read index
    logic [15:0] rdata; // Read data
    logic carrier = 1'b0, cts = 1'b0, dial_in = 1'b0, ring = 1'b0; // Modem pins
    logic rts, key, hook, dial, hang; // Outputs
    mcs_cfg_t cfg; // Settings
    int mismatches = 0, samples_checked = 0; // Verdict counters
    int dial_seen, hang_seen; // Pulse cycle counts
    always #20 clk = ~clk;
    mcs_plc_model mcs_plc_model_inst (.clk_i(clk), .rdata_i(rdata), .wr_o(rack_wr), .raddr_o(raddr));
    mcs_regs mcs_regs_inst (.CLK_I(clk), .SRST_I(srst), .RACK_WR_I(rack_wr), .PORT_WR_I(port_wr),
        .LINE_WR_I(line_wr), .RACK_RADDR_I(raddr), .RACK_RDATA_O(rdata), .CARRIER_I(carrier), .CTS_I(cts),
        .DIAL_IN_I(dial_in), .RING_I(ring), .RTS_O(rts), .RADIO_KEY_O(key), .OFF_HOOK_O(hook),
        .DIAL_START_O(dial), .HANG_UP_O(hang), .CFG_O(cfg));
    // Count pulse cycles
    always @(posedge clk) begin
        if (dial === 1'b1) dial_seen++;
        if (hang === 1'b1) hang_seen++;
    end
    task automatic finish_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] i, input logic [15:0] d);
        mcs_plc_model_inst.put_word(i, d);
    endtask : wr
    task automatic rd(input logic [3:0] i, output logic [15:0] d);
        mcs_plc_model_inst.get_word(i, d);
    endtask : rd
    // Write from the serial port or the line port
    task automatic src_wr(input bit ln, input logic [3:0] i, input logic [15:0] d);
        @(negedge clk);
        if (ln) line_wr = '{1'b1, i, d};
        else port_wr = '{1'b1, i, d};
        @(negedge clk);
        port_wr.en = 1'b0;
        line_wr.en = 1'b0;
    endtask : src_wr
    task automatic wait_hook(input logic lvl);
        int n = 0;
        while (hook !== lvl && n < 8) begin
            @(negedge clk);
            n++;
        end
        check("off hook", 16'(hook), 16'(lvl));
        if (hook !== lvl) finish_test();
    endtask : wait_hook
    task automatic t_reset;
        logic [15:0] d;
        for (int i = 1; i < 10; i++) begin
            rd(4'(i), d);
            check("reset value", d, 16'h0000);
        end
        check("reset outputs", 16'({rts, key, hook}), 16'h0000);
    endtask : t_reset
    task automatic t_cmd;
        logic [15:0] d;
        wr(4'h1, 16'h787A);
        check("rts key", 16'({rts, key}), 16'h0003);
        check("settings", 16'(cfg), 16'h070F);
        rd(4'h1, d);
        check("command", d, 16'h787A);
        rd(4'h2, d);
        check("status", d, 16'h7838);
        wr(4'h1, 16'h0000);
        check("rts key off", 16'({rts, key}), 16'h0000);
        check("settings off", 16'(cfg), 16'h0000);
    endtask : t_cmd
    task automatic t_ro;
        logic [15:0] d;
        logic [3:0] ro [6] = '{4'h2, 4'h6, 4'h8, 4'h9, 4'h0, 4'hF};
        logic [3:0] rw [4] = '{4'h3, 4'h4, 4'h5, 4'h7};
        for (int i = 0; i < 6; i++) begin
            wr(ro[i], 16'hFFFF);
            rd(ro[i], d);
            check("read-only", d, 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            wr(rw[i], 16'hA5C0 | 16'(i));
            rd(rw[i], d);
            check("read-write", d, 16'hA5C0 | 16'(i));
        end
    endtask : t_ro
    task automatic t_src;
        logic [15:0] d;
        src_wr(1'b1, 4'h4, 16'h0007);
        rd(4'h4, d);
        check("line write", d, 16'h0007);
        fork
            wr(4'h3, 16'h0011);
            src_wr(1'b0, 4'h3, 16'h0022);
        join
        rd(4'h3, d);
        check("rack priority", d, 16'h0011);
        src_wr(1'b1, 4'h8, 16'h0033);
        rd(4'h8, d);
        check("last password", d, 16'h0033);
    endtask : t_src
    task automatic t_parity;
        logic [15:0] d;
        logic [1:0] p;
        for (int k = 0; k < 5; k++) begin
            p = 2'(k % 4);
            wr(4'h1, {5'h00, p, p, 7'h00});
            rd(4'h6, d);
            check("parity", 16'({cfg.line_par, cfg.port_par}), (p == 2'h3) ? 16'h0 : 16'({p, p}));
            check("parity error", d, (p == 2'h3) ? 16'h0042 : 16'h0000);
        end
    endtask : t_parity
    task automatic t_mdrop;
        logic [15:0] v [4] = '{16'h0004, 16'h000C, 16'h2004, 16'h200C};
        for (int i = 0; i < 4; i++) begin
            wr(4'h1, v[i]);
            check("multidrop", 16'(cfg.multidrop), 16'(i == 3));
        end
        wr(4'h1, 16'h0000);
    endtask : t_mdrop
    task automatic t_dial;
        logic [15:0] d;
        logic [15:0] ptr [4] = '{16'h0009, 16'h000A, 16'h0800, 16'h0801};
        for (int i = 0; i < 4; i++) begin
            wr(4'h5, ptr[i]);
            dial_seen = 0;
            hang_seen = 0;
            wr(4'h1, 16'h0001);
            wait_hook(1'b1);
            src_wr(1'b0, 4'h1, 16'h0001);
            rd(4'h2, d);
            check("dial pulses", 16'(dial_seen), 16'(i == 1 || i == 2));
            check("hook status", 16'(d[14]), 16'h0001);
            wr(4'h1, 16'h0000);
            wait_hook(1'b0);
            repeat (2) @(negedge clk);
            check("hang pulses", 16'(hang_seen), 16'h0001);
        end
    endtask : t_dial
    task automatic t_pins;
        logic [15:0] d;
        ring = 1'b1; // Ring answered; command copy stays zero
        wait_hook(1'b1);
        wr(4'h1, 16'h0001);
        check("no action", 16'(hook), 16'h0001);
        wr(4'h1, 16'h0000);
        wait_hook(1'b0);
        carrier = 1'b1;
        cts = 1'b1;
        dial_in = 1'b1;
        wait_hook(1'b1);
        rd(4'h2, d);
        check("pins on", d & 16'h8043, 16'h0043);
        carrier = 1'b0;
        cts = 1'b0;
        dial_in = 1'b0;
        wait_hook(1'b0);
        repeat (2) @(negedge clk);
        rd(4'h2, d);
        check("pins off", d & 16'h8043, 16'h8000);
    endtask : t_pins
    initial begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_cmd();
        t_ro();
        t_src();
        t_parity();
        t_mdrop();
        t_dial();
        t_pins();
        finish_test();
    end
endmodule : mcs_regs_tb
